// File: core/rps_sequencer.sv
// Receiver power sequencer with AXI4-Lite register access
//
// Overview of operation
// - Control lines float after reset until drive bit or decoder enable.
// - After first decoder enable, lines stay driven until reset.
// - Warm-up: leading off interval (automatic only) then up to six enabled settings.
// - Automatic warm-up starts 160 ms before symbols are needed.
// - Automatic warm-up holds off setting for warm-up off time first.
// - Warm-up settings applied in order; stop at first disabled one.
// - After automatic warm-up, low or high sync per decoding state.
// - Automatic warm-up exceeding 160 ms window starts shut-down.
// - Decoder enable, noise detect or A-word search start host warm-up.
// - Host warm-up: warm settings, then high sync, or low for A-word.
// - After host warm-up, symbols invalid until high sync time expires.
// - Shut-down steps through up to three enabled settings, then off.
// - First shut-down setting disabled: go straight to off.
// - Clearing decoder enable while on or warming runs shut-down.
// - Enable during shut-down waits for shut-down to finish.
// - Sync and data settings: both symbol inputs are decoded.
// - Low sync setting for 1600 sps, high sync for 3200 sps search.
// - Sync word found: data setting matching frame rate.
// - Polled settings sample low-battery input just before leaving.
// - Differing successive low-battery samples send a status report.
// - Eight control lines carry the setting in effect.
// - Change flag set on differing samples, cleared on host read.
`timescale 1ns/1ns
module rps_sequencer
  import rps_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic                clock_i,
  input  wire logic                resetn_i,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  output logic [1:0]               s_axi_bresp_o,
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  output logic [31:0]              s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  input  wire logic                symbol_input_lo_i,
  input  wire logic                symbol_input_hi_i,
  input  wire logic                low_battery_input_i,
  output logic [LINES_W-1:0]       receiver_control_lines_o,
  output logic                     receiver_control_lines_oe_o,
  output logic                     symbols_valid_o,
  output logic                     status_report_o
);

  function automatic logic is_set(input logic [ADDR_W-1:0] a);
    return a >= ADDR_SET_BASE && a <= ADDR_SET_LAST && a[1:0] == 2'h0;
  endfunction

  function automatic logic [3:0] set_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - ADDR_SET_BASE;
    return d[5:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction

  // Step k+1 if k is below last and step k+1 is enabled, else the fallback setting
  function automatic logic [3:0] next_step(input logic [3:0] k, input logic [3:0] last,
                                           input logic [NUM_SET-1:0] en,
                                           input logic [3:0] fb);
    logic [3:0] n;
    n = k + 4'h1;
    return (k < last && en[n]) ? n : fb;
  endfunction

  rps_setting_type      set_r [NUM_SET];
  logic [NUM_SET-1:0]   en_vec;
  rps_state_type        state_r, state_nxt;
  logic [3:0]           idx_r, idx_nxt;
  logic [DUR_W-1:0]     dur_cnt_r, sv_cnt_r;
  logic [7:0]           win_cnt_r;
  logic [31:0]          div_cnt_r;
  logic                 tick_r, step_end, leaving;
  logic                 on_r, drive_bit_r, auto_hi_r, frame_hi_r, on_seen_r;
  logic                 noise_p_r, aword_p_r, auto_p_r, sync_p_r, sleep_p_r;
  logic                 on_rise, on_fall, host_req_r, req_hi_r, sync_hi_r;
  logic                 host_warm_r, win_act_r, sv_wait_r;
  logic                 lb_level_r, lb_seen_r, lbu_r, sym_lo_r, sym_hi_r;
  logic                 aw_held_r, w_held_r, do_write, stat_read;
  logic [ADDR_W-1:0]    aw_addr_r;
  logic [31:0]          w_data_r, wr_word, rd_word;
  logic [3:0]           w_strb_r;
  logic [3:0]           shut_first, host_first, sync_idx;

  always_comb begin
    for (int i = 0; i < NUM_SET; i++) begin
      en_vec[i] = set_r[i].en;
    end
  end

  // Millisecond enable; a parameter so simulation can shorten it
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt_r <= 32'h0;
      tick_r    <= 1'b0;
    end else if (div_cnt_r == 32'(TICK_CYCLES_P - 1)) begin
      div_cnt_r <= 32'h0;
      tick_r    <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 32'h1;
      tick_r    <= 1'b0;
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  assign do_write  = aw_held_r && w_held_r && !s_axi_bvalid_o;
  assign stat_read = s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == ADDR_STAT;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_r       <= 1'b0;
      w_held_r        <= 1'b0;
      aw_addr_r       <= 8'h00;
      w_data_r        <= 32'h0;
      w_strb_r        <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_r       <= 1'b1;
        aw_addr_r       <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_r       <= 1'b1;
        w_data_r       <= s_axi_wdata_i;
        w_strb_r       <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        aw_held_r      <= 1'b0;
        w_held_r       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (is_set(aw_addr_r) || aw_addr_r == ADDR_CTRL ||
                           aw_addr_r == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0;
    if (s_axi_araddr_i == ADDR_CTRL) begin
      rd_word[CTL_ON]       = on_r;
      rd_word[CTL_DRIVE]    = drive_bit_r;
      rd_word[CTL_AUTO_HI]  = auto_hi_r;
      rd_word[CTL_FRAME_HI] = frame_hi_r;
    end else if (s_axi_araddr_i == ADDR_STAT) begin
      rd_word[STB_STATE +: 3] = state_r;
      rd_word[STB_IDX +: 4]   = idx_r;
      rd_word[STB_DRIVE]      = receiver_control_lines_oe_o;
      rd_word[STB_SYMV]       = symbols_valid_o;
      rd_word[STB_LB]         = lb_level_r;
      rd_word[STB_LBU]        = lbu_r;
      rd_word[STB_SYMLO]      = sym_lo_r;
      rd_word[STB_SYMHI]      = sym_hi_r;
      rd_word[STB_PEND]       = host_req_r;
    end else if (is_set(s_axi_araddr_i)) begin
      rd_word[SET_W-1:0] = set_r[set_index(s_axi_araddr_i)];
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_word;
      s_axi_rresp_o   <= (is_set(s_axi_araddr_i) || s_axi_araddr_i == ADDR_CTRL ||
                          s_axi_araddr_i == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ---------------- Configuration ----------------
  assign wr_word = merge({{(32 - SET_W){1'b0}}, set_r[set_index(aw_addr_r)]},
                         w_data_r, w_strb_r);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_SET; i++) begin
        set_r[i] <= '0;
      end
    end else if (do_write && is_set(aw_addr_r)) begin
      set_r[set_index(aw_addr_r)] <= rps_setting_type'(wr_word[SET_W-1:0]);
    end
  end

  // Request bits are one-cycle pulses; they never read back
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      on_r        <= 1'b0;
      drive_bit_r <= 1'b0;
      auto_hi_r   <= 1'b0;
      frame_hi_r  <= 1'b0;
      noise_p_r   <= 1'b0;
      aword_p_r   <= 1'b0;
      auto_p_r    <= 1'b0;
      sync_p_r    <= 1'b0;
      sleep_p_r   <= 1'b0;
    end else begin
      noise_p_r <= 1'b0;
      aword_p_r <= 1'b0;
      auto_p_r  <= 1'b0;
      sync_p_r  <= 1'b0;
      sleep_p_r <= 1'b0;
      if (do_write && aw_addr_r == ADDR_CTRL && w_strb_r[0]) begin
        on_r        <= w_data_r[CTL_ON];
        drive_bit_r <= w_data_r[CTL_DRIVE];
        auto_hi_r   <= w_data_r[CTL_AUTO_HI];
        frame_hi_r  <= w_data_r[CTL_FRAME_HI];
        noise_p_r   <= w_data_r[CTL_NOISE];
        aword_p_r   <= w_data_r[CTL_AWORD];
        auto_p_r    <= w_data_r[CTL_AUTO];
        sync_p_r    <= w_data_r[CTL_SYNC_FOUND];
      end
      if (do_write && aw_addr_r == ADDR_CTRL && w_strb_r[1]) begin
        sleep_p_r <= w_data_r[CTL_SLEEP];
      end
    end
  end

  // ---------------- Sequencer ----------------
  logic on_d_r;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) on_d_r <= 1'b0;
    else on_d_r <= on_r;
  end
  assign on_rise  = on_r && !on_d_r;
  assign on_fall  = !on_r && on_d_r;
  assign step_end = tick_r && dur_cnt_r == '0;

  assign sync_idx   = sync_hi_r ? IDX_SYNC_HI : IDX_SYNC_LO;
  assign shut_first = next_step(IDX_DATA_HI, IDX_SHUT3, en_vec, IDX_OFF);
  assign host_first = next_step(IDX_OFF, IDX_WARM6, en_vec,
                                req_hi_r ? IDX_SYNC_HI : IDX_SYNC_LO);

  // Host requests wait here while a shut-down completes
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_req_r <= 1'b0;
      req_hi_r   <= 1'b0;
    end else if (on_rise || noise_p_r || aword_p_r) begin
      host_req_r <= state_r == RPS_IDLE || state_r == RPS_SHUT;
      req_hi_r   <= on_rise || noise_p_r;
    end else if (state_r == RPS_IDLE) begin
      host_req_r <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    case (state_r)
      RPS_IDLE: begin
        if (host_req_r) begin
          idx_nxt   = host_first;
          state_nxt = (host_first >= IDX_SYNC_LO) ? RPS_SYNC : RPS_WARM;
        end else if (auto_p_r && on_r) begin
          idx_nxt   = IDX_OFF;
          state_nxt = RPS_WOFF;
        end
      end
      RPS_WOFF, RPS_WARM: begin
        if (on_fall || (win_act_r && tick_r && win_cnt_r == 8'h00)) begin
          idx_nxt   = shut_first;
          state_nxt = (shut_first == IDX_OFF) ? RPS_IDLE : RPS_SHUT;
        end else if (step_end) begin
          idx_nxt   = next_step(idx_r, IDX_WARM6, en_vec, sync_idx);
          state_nxt = (idx_nxt == sync_idx) ? RPS_SYNC : RPS_WARM;
        end
      end
      RPS_SYNC, RPS_DATA: begin
        if (on_fall || sleep_p_r) begin
          idx_nxt   = shut_first;
          state_nxt = (shut_first == IDX_OFF) ? RPS_IDLE : RPS_SHUT;
        end else if (sync_p_r) begin
          idx_nxt   = frame_hi_r ? IDX_DATA_HI : IDX_DATA_LO;
          state_nxt = RPS_DATA;
        end
      end
      RPS_SHUT: begin
        if (step_end) begin
          idx_nxt   = next_step(idx_r, IDX_SHUT3, en_vec, IDX_OFF);
          state_nxt = (idx_nxt == IDX_OFF) ? RPS_IDLE : RPS_SHUT;
        end
      end
      default: begin
        idx_nxt   = IDX_OFF;
        state_nxt = RPS_IDLE;
      end
    endcase
  end

  assign leaving = idx_nxt != idx_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r   <= RPS_IDLE;
      idx_r     <= IDX_OFF;
      dur_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      if (leaving || (state_r == RPS_IDLE && state_nxt == RPS_WOFF)) begin
        dur_cnt_r <= set_r[idx_nxt].dur;
      end else if (tick_r && dur_cnt_r != '0) begin
        dur_cnt_r <= dur_cnt_r - 16'h1;
      end
    end
  end

  // 160 ms window from the start of an automatic warm-up
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      win_act_r   <= 1'b0;
      win_cnt_r   <= 8'h00;
      sync_hi_r   <= 1'b0;
      host_warm_r <= 1'b0;
    end else if (state_r == RPS_IDLE && state_nxt == RPS_WOFF) begin
      win_act_r   <= 1'b1;
      win_cnt_r   <= 8'(WARM_WINDOW_MS - 1);
      sync_hi_r   <= auto_hi_r;
      host_warm_r <= 1'b0;
    end else if (state_r == RPS_IDLE && state_nxt != RPS_IDLE) begin
      win_act_r   <= 1'b0;
      sync_hi_r   <= req_hi_r;
      host_warm_r <= 1'b1;
    end else if (win_act_r && tick_r) begin
      win_act_r <= win_cnt_r != 8'h00 && (state_r == RPS_WOFF || state_r == RPS_WARM);
      win_cnt_r <= win_cnt_r - 8'h1;
    end
  end

  // Symbols valid after the high-rate sync warm-up time on host starts
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sv_wait_r       <= 1'b0;
      sv_cnt_r        <= '0;
      symbols_valid_o <= 1'b0;
      sym_lo_r        <= 1'b0;
      sym_hi_r        <= 1'b0;
    end else begin
      if (state_nxt == RPS_SYNC && state_r != RPS_SYNC && state_r != RPS_DATA) begin
        sv_wait_r <= host_warm_r || state_r == RPS_IDLE;
        sv_cnt_r  <= set_r[IDX_SYNC_HI].dur;
      end else if (sv_wait_r && tick_r) begin
        if (sv_cnt_r == '0) sv_wait_r <= 1'b0;
        else sv_cnt_r <= sv_cnt_r - 16'h1;
      end
      symbols_valid_o <= (state_r == RPS_SYNC || state_r == RPS_DATA) && !sv_wait_r;
      if (symbols_valid_o) begin
        sym_lo_r <= symbol_input_lo_i;
        sym_hi_r <= symbol_input_hi_i;
      end
    end
  end

  // ---------------- Control lines ----------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      on_seen_r                   <= 1'b0;
      receiver_control_lines_oe_o <= 1'b0;
      receiver_control_lines_o    <= 8'h00;
    end else begin
      if (on_r) on_seen_r <= 1'b1;
      receiver_control_lines_oe_o <= drive_bit_r || on_r || on_seen_r;
      receiver_control_lines_o    <= set_r[idx_nxt].lines;
    end
  end

  // Low-battery poll; a new change wins over a clearing read
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lb_level_r      <= 1'b0;
      lb_seen_r       <= 1'b0;
      lbu_r           <= 1'b0;
      status_report_o <= 1'b0;
    end else begin
      status_report_o <= 1'b0;
      if (stat_read) lbu_r <= 1'b0;
      if (leaving && set_r[idx_r].poll) begin
        lb_level_r <= low_battery_input_i;
        lb_seen_r  <= 1'b1;
        if (lb_seen_r && lb_level_r != low_battery_input_i) begin
          lbu_r           <= 1'b1;
          status_report_o <= 1'b1;
        end
      end
    end
  end

endmodule

// File: include/rps_pkg.sv
// Constants, types and register map of the receiver power sequencer
package rps_pkg;
  localparam int CLK_HZ         = 25_000_000;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int WARM_WINDOW_MS = 160;
  localparam int NUM_SET        = 14;
  localparam int DUR_W          = 16;
  localparam int LINES_W        = 8;
  localparam int ADDR_W         = 8;

  localparam logic [3:0] IDX_OFF     = 4'h0;
  localparam logic [3:0] IDX_WARM1   = 4'h1;
  localparam logic [3:0] IDX_WARM6   = 4'h6;
  localparam logic [3:0] IDX_SYNC_LO = 4'h7;
  localparam logic [3:0] IDX_SYNC_HI = 4'h8;
  localparam logic [3:0] IDX_DATA_LO = 4'h9;
  localparam logic [3:0] IDX_DATA_HI = 4'hA;
  localparam logic [3:0] IDX_SHUT1   = 4'hB;
  localparam logic [3:0] IDX_SHUT3   = 4'hD;

  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SET_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_SET_LAST = 8'h74;

  localparam int CTL_ON         = 0;
  localparam int CTL_DRIVE      = 1;
  localparam int CTL_NOISE      = 2;
  localparam int CTL_AWORD      = 3;
  localparam int CTL_AUTO       = 4;
  localparam int CTL_AUTO_HI    = 5;
  localparam int CTL_SYNC_FOUND = 6;
  localparam int CTL_FRAME_HI   = 7;
  localparam int CTL_SLEEP      = 8;

  localparam int STB_STATE = 0;
  localparam int STB_IDX   = 4;
  localparam int STB_DRIVE = 8;
  localparam int STB_SYMV  = 9;
  localparam int STB_LB    = 10;
  localparam int STB_LBU   = 11;
  localparam int STB_SYMLO = 12;
  localparam int STB_SYMHI = 13;
  localparam int STB_PEND  = 14;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RPS_IDLE = 3'h0,
    RPS_WOFF = 3'h1,
    RPS_WARM = 3'h3,
    RPS_SYNC = 3'h2,
    RPS_DATA = 3'h6,
    RPS_SHUT = 3'h7
  } rps_state_type;

  typedef struct packed {
    logic               poll;
    logic               en;
    logic [DUR_W-1:0]   dur;
    logic [LINES_W-1:0] lines;
  } rps_setting_type;

  localparam int SET_W = $bits(rps_setting_type);
endpackage

// File: verification/rps_rx_model.sv
// Behavioural model of the paging receiver on the control lines
`timescale 1ns/1ns
module rps_rx_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] lines_i,
  input  wire logic       oe_i,
  input  wire logic       lb_level_i,
  output logic            sym_lo_o,
  output logic            sym_hi_o,
  output logic            lb_o
);
  logic [1:0] cnt_r = 2'h0;

  always_ff @(posedge clock_i) begin
    cnt_r <= cnt_r + 2'h1;
  end

  // Unpowered receiver gives changing noise, never a held value
  assign sym_lo_o = cnt_r[0];
  assign sym_hi_o = (oe_i && lines_i != 8'h00) ? cnt_r[1] : ~cnt_r[0];
  assign lb_o     = lb_level_i;
endmodule

// File: verification/rps_sequencer_sva.sv
// Concurrent checks on the sequencer's host and line ports
`timescale 1ns/1ns
module rps_sequencer_sva
  import rps_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        receiver_control_lines_oe_o,
  input wire logic        status_report_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_ans;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
  property p_b_ans;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> (!s_axi_awready_o && !s_axi_wready_o) ##1 s_axi_bvalid_o;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
  property p_aw_busy;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("write taken while busy");
  property p_err_zero;
    s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR |-> s_axi_rdata_o == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_rep_pulse;
    status_report_o |=> !status_report_o;
  endproperty
  a_rep_pulse: assert property (p_rep_pulse) else $error("report not a pulse");
  property p_oe_cause;
    $rose(receiver_control_lines_oe_o) |-> $past(s_axi_bvalid_o);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("lines driven uncaused");
endmodule

bind rps_sequencer rps_sequencer_sva #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_sva (
  .clock_i(clock_i), .resetn_i(resetn_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i),
  .receiver_control_lines_oe_o(receiver_control_lines_oe_o),
  .status_report_o(status_report_o)
);

// File: verification/tb.sv
// Self-checking bench for the receiver power sequencer
`timescale 1ns/1ns
module tb;
  import rps_pkg::*;
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lines;
  logic [31:0] wdata = 32'h0, rdata, rdat;
  logic [3:0]  wstrb = 4'h0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic        lb_lvl = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic        sym_lo, sym_hi, lb, oe, symv, rep;
  logic [1:0]  bresp, rresp, rrs;
  int          err_total = 0, cmp_count = 0, cyc = 0, rep_n = 0, n;

  rps_sequencer #(.TICK_CYCLES_P(4)) dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .symbol_input_lo_i(sym_lo), .symbol_input_hi_i(sym_hi),
    .low_battery_input_i(lb), .receiver_control_lines_o(lines),
    .receiver_control_lines_oe_o(oe), .symbols_valid_o(symv), .status_report_o(rep)
  );
  rps_rx_model u_rx (
    .clock_i(clock_i), .lines_i(lines), .oe_i(oe), .lb_level_i(lb_lvl),
    .sym_lo_o(sym_lo), .sym_hi_o(sym_hi), .lb_o(lb)
  );

  always #20 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    cyc++;
    if (rep === 1'b1) rep_n++;
    if (cyc == 20000) begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      results();
    end
  end

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Response is held back a cycle so the slave's hold is exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    {awaddr, wdata, wstrb, awv, wv} <= {a, d, s, 2'b11};
    do begin
      @(posedge clock_i);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while ((awv && !awready) || (wv && !wready));
    while (bvalid !== 1'b1) @(posedge clock_i);
    bready <= 1'b1;
    @(posedge clock_i);
    rrs = bresp;
    bready <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a);
    {araddr, arv} <= {a, 1'b1};
    do @(posedge clock_i); while (arready !== 1'b1);
    arv <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock_i);
    rready <= 1'b1;
    @(posedge clock_i);
    {rdat, rrs} = {rdata, rresp};
    rready <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic sw(input logic [3:0] i, input logic [7:0] l, input logic [15:0] d,
                    input logic [1:0] pe);
    wr(ADDR_SET_BASE + {2'h0, i, 2'h0}, {6'h0, pe, d, l}, 4'hF);
  endtask

  task automatic wl(input logic [7:0] v);
    n = 0;
    while (lines !== v && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    chk({24'h0, lines}, {24'h0, v});
  endtask

  task automatic t_reset;
    chk({31'h0, oe}, 32'h0);
    rd(ADDR_STAT);
    chk(rdat, 32'h0);
    wr(ADDR_CTRL, 32'h2, 4'hF);
    chk({31'h0, oe}, 32'h1);
    $display("t_reset done");
  endtask

  task automatic t_regs;
    sw(4'h1, 8'h11, 16'h2, 2'b01);
    rd(ADDR_SET_BASE + 8'h04);
    chk(rdat, 32'h0100_0211);
    rd(8'h20);
    chk({rdat[31:2], rrs}, {30'h0, RESP_SLVERR});
    wr(8'h80, 32'h1, 4'hF);
    chk({30'h0, rrs}, {30'h0, RESP_SLVERR});
    $display("t_regs done");
  endtask

  task automatic t_host;
    sw(4'h0, 8'h00, 16'h3, 2'b01);
    sw(4'h2, 8'h22, 16'h2, 2'b01);
    sw(4'h7, 8'h77, 16'h1, 2'b01);
    sw(4'h8, 8'h88, 16'h3, 2'b11);
    sw(4'hA, 8'hAA, 16'h1, 2'b01);
    sw(4'hB, 8'hB1, 16'h3, 2'b01);
    sw(4'hC, 8'hB2, 16'h1, 2'b11);
    wr(ADDR_CTRL, 32'h1, 4'hF);
    wl(8'h11);
    chk({31'h0, n < 6}, 32'h1);
    wl(8'h22);
    wl(8'h88);
    chk({31'h0, symv}, 32'h0);
    n = 0;
    while (symv !== 1'b1 && n < 100) begin
      @(posedge clock_i);
      n++;
    end
    chk({31'h0, n > 9 && n < 20}, 32'h1);
    $display("t_host done");
  endtask

  task automatic t_shut;
    wr(ADDR_CTRL, 32'h0, 4'hF);
    wl(8'hB1);
    lb_lvl <= 1'b1;
    wl(8'hB2);
    wl(8'h00);
    // Let the pulse counter see the report edge before judging it
    @(posedge clock_i);
    chk(rep_n, 1);
    rd(ADDR_STAT);
    chk(rdat & 32'hC00, 32'hC00);
    rd(ADDR_STAT);
    chk(rdat & 32'h800, 32'h0);
    chk({31'h0, oe}, 32'h1);
    $display("t_shut done");
  endtask

  task automatic t_aword;
    sw(4'hB, 8'hB1, 16'h3, 2'b00);
    wr(ADDR_CTRL, 32'h8, 4'hF);
    wl(8'h11);
    wl(8'h22);
    wl(8'h77);
    wr(ADDR_CTRL, 32'h100, 4'h2);
    wl(8'h00);
    chk({31'h0, n < 6}, 32'h1);
    $display("t_aword done");
  endtask

  task automatic t_auto;
    wr(ADDR_CTRL, 32'h1, 4'hF);
    wl(8'h88);
    wr(ADDR_CTRL, 32'h101, 4'h3);
    wl(8'h00);
    wr(ADDR_CTRL, 32'h31, 4'h1);
    wl(8'h11);
    chk({31'h0, n > 8}, 32'h1);
    wl(8'h22);
    wl(8'h88);
    repeat (2) @(posedge clock_i);
    chk({31'h0, symv}, 32'h1);
    wr(ADDR_CTRL, 32'hE1, 4'h1);
    wl(8'hAA);
    $display("t_auto done");
  endtask

  task automatic t_reen;
    sw(4'hB, 8'hB1, 16'h3, 2'b01);
    wr(ADDR_CTRL, 32'hA0, 4'h1);
    wl(8'hB1);
    wr(ADDR_CTRL, 32'h1, 4'h1);
    wl(8'hB2);
    wl(8'h11);
    chk({31'h0, oe}, 32'h1);
    $display("t_reen done");
  endtask

  // Long warm step overruns the 160-tick window, which must cut it short
  task automatic t_win;
    wl(8'h88);
    sw(4'h2, 8'h22, 16'h00C8, 2'b01);
    wr(ADDR_CTRL, 32'h101, 4'h3);
    wl(8'h00);
    wr(ADDR_CTRL, 32'h11, 4'h1);
    wl(8'h22);
    wl(8'hB1);
    chk({31'h0, n > 590 && n < 640}, 32'h1);
    $display("t_win done");
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_regs();
    t_host();
    t_shut();
    t_aword();
    t_auto();
    t_reen();
    t_win();
    results();
  end
endmodule
